/* logic/ubt_core.v */
// ubt_core.v: uart core, host register map, rate divider, modem pins
// assumes: host strobes and serial/modem pins are asynchronous to i_clk
//
// Function
// - divide osc by 16-bit divisor for 16x
// - each transmitted bit lasts sixteen ticks
// - start, data, optional parity, stop bits
// - data bit 0 leaves the line first
// - holding-empty set when byte moves to shifter
// - holding-empty interrupt when enable bit 1
// - idle flag when holding and shifter empty
// - start validated by sample after eight ticks
// - later bits sampled mid-bit, sixteen apart
// - parity, framing, break tags in status 2-4
// - reading rx byte refreshes the error tags
// - rx ready interrupt when enable bit 0
// - enhanced features need enable bit 5
// - soft reset ORed onto reset output
// - power down keeps configuration intact
// - loopback routes tx to rx, mutes pins
// - divisor latch bit banks offsets 0,1
// - offset 0 data, offset 7 scratch
// - reset output follows reset input otherwise
// - hardware reset restores configuration defaults
`timescale 1ns/1ps
`default_nettype none
`include "ubt_defines.vh"

module ubt_core (
    input wire i_clk,
    input wire i_rst,
    input wire [2:0] i_addr,
    input wire i_cs,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output wire o_irq,
    output wire o_rst_out,
    output reg o_txd,
    input wire i_rxd,
    output reg o_rts_n,
    output reg o_dtr_n,
    input wire i_cts_n,
    input wire i_dsr_n,
    input wire i_cd_n,
    input wire i_ri_n
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers: stage one only feeds stage two
reg [6:0] s1_q;
reg [6:0] s2_q;
always @(posedge i_clk) begin
    s1_q <= {i_cs, i_rd, i_wr, i_rxd, i_cts_n, i_dsr_n, i_cd_n};
    s2_q <= s1_q;
end
reg ri1_q;
reg ri2_q;
always @(posedge i_clk) begin
    ri1_q <= i_ri_n;
    ri2_q <= ri1_q;
end
wire cs_s = s2_q[6];
wire rd_s = s2_q[5];
wire wr_s = s2_q[4];
wire rxd_s = s2_q[3];

reg rd_d1_q;
reg wr_d1_q;
always @(posedge i_clk) begin
    rd_d1_q <= cs_s & rd_s;
    wr_d1_q <= cs_s & wr_s;
end
// one access per strobe, taken on its rising edge
wire rd_p = cs_s & rd_s & ~rd_d1_q;
wire wr_p = cs_s & wr_s & ~wr_d1_q;

////////////////////////////////////////////////////////////////////////
reg [7:0] ier_q;
reg [7:0] lcr_q;
reg [7:0] mcr_q;
reg [7:0] scr_q;
reg [7:0] dll_q;
reg [7:0] dlm_q;
reg [7:0] thr_q;
reg thr_full_q;
reg [7:0] rhr_q;
reg rhr_full_q;
reg perr_q;
reg ferr_q;
reg brk_q;
reg ovr_q;
reg thre_ack_q;
reg [3:0] dmsr_q;
reg [3:0] msr_prev_q;
reg [3:0] isr_code;

wire dlab = lcr_q[`UBT_LCR_DLAB];
wire special = ier_q[`UBT_IER_SPECIAL];
wire loop = mcr_q[`UBT_MCR_LOOP];
wire pdown = special & mcr_q[`UBT_MCR_PDOWN];

// loopback takes modem inputs from the control bits
wire [3:0] msr_now = loop ?
    {mcr_q[`UBT_MCR_INTEN], mcr_q[`UBT_MCR_SOFTRST],
     mcr_q[`UBT_MCR_DTR], mcr_q[`UBT_MCR_RTS]} :
    {~s2_q[0], ~ri2_q, ~s2_q[1], ~s2_q[2]};

////////////////////////////////////////////////////////////////////////
// rate divider: one tick every divisor cycles, stopped in power down
reg [15:0] div_cnt_q;
reg tick_q;
wire [15:0] divisor = {dlm_q, dll_q};
always @(posedge i_clk) begin
    if (i_rst || pdown) begin
        div_cnt_q <= 16'h0000;
        tick_q <= 1'b0;
    end else if (div_cnt_q + 16'h0001 >= divisor) begin
        div_cnt_q <= 16'h0000;
        tick_q <= 1'b1;
    end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
        tick_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
wire tx_busy;
wire tx_take;
wire tx_line;
ubt_tx u_tx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(tick_q),
    .i_load(thr_full_q & ~pdown),
    .i_data(thr_q),
    .i_lcr(lcr_q),
    .o_busy(tx_busy),
    .o_take(tx_take),
    .o_line(tx_line)
);

wire rx_done;
wire [7:0] rx_data;
wire rx_perr;
wire rx_ferr;
wire rx_brk;
wire rx_in = loop ? tx_line : rxd_s;
ubt_rx u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(tick_q),
    .i_line(rx_in),
    .i_lcr(lcr_q),
    .o_done(rx_done),
    .o_data(rx_data),
    .o_perr(rx_perr),
    .o_ferr(rx_ferr),
    .o_brk(rx_brk)
);

////////////////////////////////////////////////////////////////////////
wire rd_data = rd_p && i_addr == `UBT_OFS_DATA && !dlab;
wire rd_lsr = rd_p && i_addr == `UBT_OFS_LSR;
wire rd_msr = rd_p && i_addr == `UBT_OFS_MSR;
wire wr_thr = wr_p && i_addr == `UBT_OFS_DATA && !dlab;
wire thre = ~thr_full_q;
wire temt = ~thr_full_q & ~tx_busy;

always @(posedge i_clk) begin
    if (i_rst) begin
        ier_q <= `UBT_IER_RST;
        lcr_q <= `UBT_LCR_RST;
        mcr_q <= `UBT_MCR_RST;
        dll_q <= `UBT_DLL_RST;
        dlm_q <= `UBT_DLM_RST;
        scr_q <= 8'h00;
        thr_q <= 8'h00;
    end else if (wr_p) begin
        case (i_addr)
        `UBT_OFS_DATA: if (dlab) dll_q <= i_wdata;
                       else thr_q <= i_wdata;
        `UBT_OFS_IER: if (dlab) dlm_q <= i_wdata;
                      else ier_q <= i_wdata & 8'h2F;
        `UBT_OFS_LCR: lcr_q <= i_wdata;
        `UBT_OFS_MCR: mcr_q <= i_wdata & 8'h9F;
        `UBT_OFS_SCR: scr_q <= i_wdata;
        default: ;
        endcase
    end
end

// transmit holding: write wins over a same-cycle take
always @(posedge i_clk) begin
    if (i_rst) begin
        thr_full_q <= 1'b0;
        thre_ack_q <= 1'b0;
    end else begin
        if (wr_thr)
            thr_full_q <= 1'b1;
        else if (tx_take)
            thr_full_q <= 1'b0;
        if (wr_thr || tx_take)
            thre_ack_q <= 1'b0;
        else if (rd_p && i_addr == `UBT_OFS_ISR && isr_code == `UBT_ISR_TX)
            thre_ack_q <= 1'b1;
    end
end

// receive holding and tags; a new byte wins over a same-cycle read
always @(posedge i_clk) begin
    if (i_rst) begin
        rhr_q <= 8'h00;
        rhr_full_q <= 1'b0;
        perr_q <= 1'b0;
        ferr_q <= 1'b0;
        brk_q <= 1'b0;
        ovr_q <= 1'b0;
    end else begin
        if (rx_done) begin
            rhr_q <= rx_data;
            rhr_full_q <= 1'b1;
            perr_q <= rx_perr;
            ferr_q <= rx_ferr;
            brk_q <= rx_brk;
        end else if (rd_data) begin
            // single byte holding: tags now describe an empty register
            rhr_full_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            brk_q <= 1'b0;
        end
        if (rx_done && rhr_full_q && !rd_data)
            ovr_q <= 1'b1;
        else if (rd_lsr)
            ovr_q <= 1'b0;
    end
end

// modem deltas; a change wins over the clearing read
always @(posedge i_clk) begin
    if (i_rst) begin
        dmsr_q <= 4'h0;
        msr_prev_q <= 4'h0;
    end else begin
        msr_prev_q <= msr_now;
        dmsr_q <= (rd_msr ? 4'h0 : dmsr_q) | (msr_now ^ msr_prev_q);
    end
end

////////////////////////////////////////////////////////////////////////
wire [7:0] line_status = {1'b0, temt, thre, brk_q, ferr_q, perr_q, ovr_q,
                  rhr_full_q};
wire line_err = ovr_q | perr_q | ferr_q | brk_q;
always @* begin
    if (ier_q[`UBT_IER_RLS] && line_err)
        isr_code = `UBT_ISR_RLS;
    else if (ier_q[`UBT_IER_RXRDY] && rhr_full_q)
        isr_code = `UBT_ISR_RX;
    else if (ier_q[`UBT_IER_THRE] && thre && !thre_ack_q)
        isr_code = `UBT_ISR_TX;
    else if (ier_q[`UBT_IER_MS] && dmsr_q != 4'h0)
        isr_code = `UBT_ISR_MS;
    else
        isr_code = `UBT_ISR_NONE;
end

wire [7:0] interrupt_status = {2'b00,
    special & ~thr_full_q, special & rhr_full_q, isr_code};
assign o_irq = ~isr_code[0] & mcr_q[`UBT_MCR_INTEN] & ~loop;

// soft reset only under enhanced mode, reset pin passes through always
assign o_rst_out = i_rst |
    (special & mcr_q[`UBT_MCR_SOFTRST]);

always @(posedge i_clk) begin
    if (i_rst)
        o_rdata <= 8'h00;
    else if (rd_p) begin
        case (i_addr)
        `UBT_OFS_DATA: o_rdata <= dlab ? dll_q : rhr_q;
        `UBT_OFS_IER: o_rdata <= dlab ? dlm_q : ier_q;
        `UBT_OFS_ISR: o_rdata <= interrupt_status;
        `UBT_OFS_LCR: o_rdata <= lcr_q;
        `UBT_OFS_MCR: o_rdata <= mcr_q;
        `UBT_OFS_LSR: o_rdata <= line_status;
        `UBT_OFS_MSR: o_rdata <= {msr_now, dmsr_q};
        `UBT_OFS_SCR: o_rdata <= scr_q;
        default: o_rdata <= 8'h00;
        endcase
    end
end

// loopback parks tx at mark and deasserts modem outputs
always @(posedge i_clk) begin
    if (i_rst) begin
        o_txd <= 1'b1;
        o_rts_n <= 1'b1;
        o_dtr_n <= 1'b1;
    end else begin
        o_txd <= loop ? 1'b1 : (tx_line & ~lcr_q[`UBT_LCR_BREAK]);
        o_rts_n <= loop | ~mcr_q[`UBT_MCR_RTS];
        o_dtr_n <= loop | ~mcr_q[`UBT_MCR_DTR];
    end
end

endmodule
`default_nettype wire

/* logic/ubt_defines.vh */
// ubt_defines.vh: register offsets, field positions, reset values
// assumes: included by the ubt design files by bare name
`ifndef UBT_DEFINES_VH
`define UBT_DEFINES_VH

`define UBT_OFS_DATA 3'h0
`define UBT_OFS_IER 3'h1
`define UBT_OFS_ISR 3'h2
`define UBT_OFS_LCR 3'h3
`define UBT_OFS_MCR 3'h4
`define UBT_OFS_LSR 3'h5
`define UBT_OFS_MSR 3'h6
`define UBT_OFS_SCR 3'h7

`define UBT_IER_RXRDY 0
`define UBT_IER_THRE 1
`define UBT_IER_RLS 2
`define UBT_IER_MS 3
`define UBT_IER_SPECIAL 5

`define UBT_LCR_STOP 2
`define UBT_LCR_PEN 3
`define UBT_LCR_EVEN 4
`define UBT_LCR_STICK 5
`define UBT_LCR_BREAK 6
`define UBT_LCR_DLAB 7

`define UBT_MCR_DTR 0
`define UBT_MCR_RTS 1
`define UBT_MCR_SOFTRST 2
`define UBT_MCR_INTEN 3
`define UBT_MCR_LOOP 4
`define UBT_MCR_PDOWN 7

`define UBT_IER_RST 8'h00
`define UBT_LCR_RST 8'h00
`define UBT_MCR_RST 8'h00
`define UBT_DLL_RST 8'h01
`define UBT_DLM_RST 8'h00

`define UBT_OVERSAMPLE 5'h10
`define UBT_HALF_BIT 4'h7
`define UBT_LAST_TICK 4'hF

`define UBT_ISR_NONE 4'h1
`define UBT_ISR_RLS 4'h6
`define UBT_ISR_RX 4'h4
`define UBT_ISR_TX 4'h2
`define UBT_ISR_MS 4'h0

`endif

/* logic/ubt_tx.v */
// ubt_tx.v: transmit shifter, start/data/parity/stop framing
// assumes: i_tick is a one-cycle 16x sampling enable on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "ubt_defines.vh"

module ubt_tx (
    input wire i_clk,
    input wire i_rst,
    input wire i_tick,
    input wire i_load,
    input wire [7:0] i_data,
    input wire [7:0] i_lcr,
    output reg o_busy,
    output reg o_take,
    output reg o_line
);

reg [3:0] tick_q;
reg [3:0] bit_q;
reg [10:0] frame_q;
reg [3:0] nbits_q;

wire [3:0] word_len = {2'b00, i_lcr[1:0]} + 4'h5;
wire [7:0] mask = 8'hFF >> (4'h8 - word_len);
wire [7:0] dmask = i_data & mask;
wire par_odd = ^dmask;
wire par_bit = i_lcr[`UBT_LCR_STICK] ? ~i_lcr[`UBT_LCR_EVEN]
             : (i_lcr[`UBT_LCR_EVEN] ? par_odd : ~par_odd);
wire [3:0] nstop = i_lcr[`UBT_LCR_STOP] ? 4'h2 : 4'h1;
wire [3:0] npar = i_lcr[`UBT_LCR_PEN] ? 4'h1 : 4'h0;

////////////////////////////////////////////////////////////////////////
always @(posedge i_clk) begin
    o_take <= 1'b0;
    if (i_rst) begin
        o_busy <= 1'b0;
        tick_q <= 4'h0;
        bit_q <= 4'h0;
        frame_q <= 11'h7FF;
        nbits_q <= 4'h0;
    end else if (!o_busy) begin
        // start on a tick so every bit spans whole tick periods
        if (i_load && i_tick) begin
            // data lsb first, parity after the last data bit
            frame_q <= ({3'b111, dmask} |
                        (11'h7FF << (word_len + npar))) &
                       ~({10'h000, i_lcr[`UBT_LCR_PEN]} << word_len) |
                       ({10'h000, par_bit & i_lcr[`UBT_LCR_PEN]}
                        << word_len);
            nbits_q <= 4'h1 + word_len + npar + nstop;
            o_busy <= 1'b1;
            o_take <= 1'b1;
            bit_q <= 4'h0;
            tick_q <= 4'h0;
        end
    end else if (i_tick) begin
        tick_q <= tick_q + 4'h1;
        if (tick_q == `UBT_LAST_TICK) begin
            if (bit_q != 4'h0)
                frame_q <= {1'b1, frame_q[10:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q + 4'h1 == nbits_q)
                o_busy <= 1'b0;
        end
    end
end

always @(posedge i_clk) begin
    if (i_rst)
        o_line <= 1'b1;
    else if (o_busy && bit_q == 4'h0)
        o_line <= 1'b0 & ~(i_tick && tick_q == `UBT_LAST_TICK);
    else if (o_busy)
        o_line <= (bit_q == 4'h1 && tick_q == 4'h0) ? frame_q[0]
                : frame_q[0];
    else
        o_line <= 1'b1;
end

endmodule
`default_nettype wire

/* logic/ubt_rx.v */
// ubt_rx.v: receive shifter with centre sampling and error tags
// assumes: i_line is already synchronised to i_clk
`timescale 1ns/1ps
`default_nettype none
`include "ubt_defines.vh"

module ubt_rx (
    input wire i_clk,
    input wire i_rst,
    input wire i_tick,
    input wire i_line,
    input wire [7:0] i_lcr,
    output reg o_done,
    output reg [7:0] o_data,
    output reg o_perr,
    output reg o_ferr,
    output reg o_brk
);

localparam ST_IDLE = 2'd0;
localparam ST_START = 2'd1;
localparam ST_BITS = 2'd2;

reg [1:0] st_q;
reg [3:0] tick_q;
reg [3:0] bit_q;
reg [9:0] sh_q;
reg prev_q;

wire [3:0] word_len = {2'b00, i_lcr[1:0]} + 4'h5;
wire [3:0] npar = i_lcr[`UBT_LCR_PEN] ? 4'h1 : 4'h0;
wire [3:0] last = word_len + npar;
wire [7:0] mask = 8'hFF >> (4'h8 - word_len);
wire [7:0] dat = sh_q[7:0] & mask;
wire pbit = sh_q[word_len];
wire pexp = i_lcr[`UBT_LCR_STICK] ? ~i_lcr[`UBT_LCR_EVEN]
          : (i_lcr[`UBT_LCR_EVEN] ? ^dat : ~^dat);

////////////////////////////////////////////////////////////////////////
always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_rst) begin
        st_q <= ST_IDLE;
        tick_q <= 4'h0;
        bit_q <= 4'h0;
        sh_q <= 10'h000;
        prev_q <= 1'b1;
        o_data <= 8'h00;
        o_perr <= 1'b0;
        o_ferr <= 1'b0;
        o_brk <= 1'b0;
    end else if (i_tick) begin
        prev_q <= i_line;
        case (st_q)
        ST_IDLE: begin
            tick_q <= 4'h0;
            if (prev_q && !i_line)
                st_q <= ST_START;
        end
        ST_START: begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == `UBT_HALF_BIT) begin
                tick_q <= 4'h0;
                bit_q <= 4'h0;
                st_q <= i_line ? ST_IDLE : ST_BITS;
            end
        end
        ST_BITS: begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == `UBT_LAST_TICK) begin
                bit_q <= bit_q + 4'h1;
                if (bit_q == last) begin
                    // stop bit sampled at its centre
                    st_q <= ST_IDLE;
                    o_done <= 1'b1;
                    o_data <= dat;
                    o_perr <= i_lcr[`UBT_LCR_PEN] & (pbit != pexp);
                    o_ferr <= ~i_line;
                    o_brk <= ~i_line && sh_q[9:0] == 10'h000 &&
                             (dat == 8'h00);
                end else begin
                    sh_q <= sh_q | ({9'h000, i_line} << bit_q);
                end
            end
        end
        default: st_q <= ST_IDLE;
        endcase
        if (st_q == ST_IDLE)
            sh_q <= 10'h000;
    end
end

endmodule
`default_nettype wire

/* tb/ubt_far_end.sv */
// ubt_far_end.sv: remote serial device model facing ubt_core
// assumes: caller gives the bit time in i_clk cycles (16 x divisor)
`timescale 1ns/1ps
`default_nettype none
module ubt_far_end (
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd
);
    initial o_rxd = 1'b1;
    // frame lsb first, start bit included; line returns to mark
    task automatic send(input logic [11:0] f, input int n, input int b);
        for (int i = 0; i < n; i++) begin
            o_rxd <= f[i];
            repeat (b) @(negedge i_clk);
        end
        o_rxd <= 1'b1;
    endtask
    // unknown result on a missing start edge so the caller sees a miss
    task automatic catch(input int n, input int b, output logic [11:0] f);
        int k;
        f = 'x;
        k = 0;
        // falling edge: away from the edge that launches the line
        while (i_txd !== 1'b0 && k < 400) begin
            @(negedge i_clk);
            k++;
        end
        if (k < 400) begin
            f = '1;
            repeat (b / 2) @(negedge i_clk);
            for (int i = 0; i < n; i++) begin
                f[i] = i_txd;
                repeat (b) @(negedge i_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

/* tb/ubt_core_asserts.sv */
// ubt_core_asserts.sv: port-level checker for ubt_core
// assumes: bound to ubt_core, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ubt_core_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq,
    input wire logic o_rst_out,
    input wire logic o_txd,
    input wire logic o_rts_n,
    input wire logic o_dtr_n
);
    // shadows lead the core by the strobe sync, hence six-cycle windows
    logic [7:0] ier_s;
    logic [7:0] mcr_s;
    logic dlab_s;
    logic [15:0] lo_run;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ier_s <= 8'h00;
            mcr_s <= 8'h00;
            dlab_s <= 1'b0;
        end else if (i_cs && i_wr) begin
            if (i_addr == 3'h1 && !dlab_s)
                ier_s <= i_wdata;
            if (i_addr == 3'h3)
                dlab_s <= i_wdata[7];
            if (i_addr == 3'h4)
                mcr_s <= i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst || o_txd)
            lo_run <= 16'h0000;
        else
            lo_run <= lo_run + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_loop_held;
        mcr_s[4] [*6];
    endsequence
    sequence s_no_read;
        !(i_cs && i_rd) [*8];
    endsequence
    a_rst_out_follow: assert property (
        $fell(i_rst) |-> $past(o_rst_out))
        else $error("reset output low during reset");
    a_rst_idle_pins: assert property (
        $fell(i_rst) |-> o_txd && o_rts_n && o_dtr_n)
        else $error("serial pins not idle after reset");
    a_bit_len: assert property (
        $rose(o_txd) |-> lo_run[3:0] == 4'h0)
        else $error("low run not whole bit times");
    a_loop_mutes: assert property (
        s_loop_held |-> o_txd && o_rts_n && o_dtr_n)
        else $error("pins active in loopback");
    a_soft_rst_on: assert property (
        (ier_s[5] && mcr_s[2]) [*6] |-> o_rst_out)
        else $error("soft reset not on reset output");
    a_soft_rst_off: assert property (
        (!ier_s[5]) [*6] |-> !o_rst_out)
        else $error("reset output high outside enhanced mode");
    a_irq_gated: assert property (
        (!mcr_s[3] || mcr_s[4]) [*6] |-> !o_irq)
        else $error("interrupt output while gated");
    a_rdata_hold: assert property (
        s_no_read |-> $stable(o_rdata))
        else $error("read data moved without a read");
endmodule
bind ubt_core ubt_core_asserts i_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_cs(i_cs),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_rst_out(o_rst_out), .o_txd(o_txd),
    .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n)
);
`default_nettype wire

/* tb/uart_baud_txrx_core_test.sv */
// uart_baud_txrx_core_test.sv: self-checking bench for ubt_core
// assumes: far-end model and bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module uart_baud_txrx_core_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic i_cs = 1'b0;
    logic i_rd = 1'b0;
    logic i_wr = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic o_irq, o_rst_out, o_txd, o_rts_n, o_dtr_n, rxd;
    logic cd_n = 1'b1;
    int n_fail = 0;
    int checks = 0;
    always #25 i_clk = ~i_clk;
    ubt_core i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_cs(i_cs),
        .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_irq(o_irq), .o_rst_out(o_rst_out), .o_txd(o_txd),
        .i_rxd(rxd), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n),
        .i_cts_n(1'b1), .i_dsr_n(1'b1), .i_cd_n(cd_n), .i_ri_n(1'b1)
    );
    ubt_far_end i_far (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] s, input logic [11:0] e,
                       input string w);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h want %h", $time, w, s, e);
        end
    endtask
    // strobes held past the three-edge sync, gap keeps accesses apart
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_addr = a;
        i_wdata = d;
        i_cs = 1'b1;
        i_wr = 1'b1;
        repeat (5) @(negedge i_clk);
        i_cs = 1'b0;
        i_wr = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_addr = a;
        i_cs = 1'b1;
        i_rd = 1'b1;
        repeat (5) @(negedge i_clk);
        d = o_rdata;
        i_cs = 1'b0;
        i_rd = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e,
                         input string w);
        logic [7:0] d;
        rd(a, d);
        chk({4'h0, d}, {4'h0, e}, w);
    endtask
    task automatic wait_irq(input logic v);
        int k;
        k = 0;
        while (o_irq !== v && k < 50) begin
            @(negedge i_clk);
            k++;
        end
        chk(o_irq, v, "irq level");
        if (k >= 50)
            print_verdict();
    endtask
    function automatic logic [11:0] frame(input logic [7:0] l,
                                          input logic [7:0] d, output int n);
        int w;
        logic [11:0] f;
        w = l[1:0] + 5;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < w; i++)
            f[i + 1] = d[i];
        n = w + 2;
        if (l[3]) begin
            f[w + 1] = ^(d & ~(8'hFF << w)) ^ !l[4];
            n++;
        end
        return f;
    endfunction
    task automatic set_fmt(input logic [7:0] dl, input logic [7:0] l);
        wr(3'h3, 8'h80);
        wr(3'h0, dl);
        wr(3'h1, 8'h00);
        wr(3'h3, l);
    endtask
    task automatic tx_one(input logic [7:0] l, input logic [7:0] d,
                          input int b);
        logic [11:0] got;
        logic [11:0] exp;
        int n;
        exp = frame(l, d, n);
        fork
            i_far.catch(n, b, got);
            begin
                wr(3'h0, d);
                rdchk(3'h5, 8'h20, "lsr busy");
            end
        join
        chk(got, exp, "tx frame");
        rdchk(3'h5, 8'h60, "lsr idle");
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(3'h4, 8'h00, "mcr reset");
        rdchk(3'h5, 8'h60, "lsr reset");
        wr(3'h3, 8'h80);
        rdchk(3'h0, 8'h01, "div reset");
        wr(3'h1, 8'h09);
        rdchk(3'h1, 8'h09, "div high");
        wr(3'h3, 8'h00);
        rdchk(3'h1, 8'h00, "ier banked");
        wr(3'h1, 8'hFF);
        rdchk(3'h1, 8'h2F, "ier bits");
        wr(3'h1, 8'h00);
        wr(3'h7, 8'hA5);
        wr(3'h5, 8'h00);
        rdchk(3'h7, 8'hA5, "scratch");
        rdchk(3'h5, 8'h60, "lsr ro");
        $display("test regs done");
    endtask
    task automatic t_tx();
        logic [7:0] lc [3];
        logic [7:0] dv [3];
        lc = '{8'h03, 8'h1B, 8'h08};
        dv = '{8'hA5, 8'h6E, 8'h13};
        for (int k = 0; k < 3; k++) begin
            set_fmt(8'(k + 1), lc[k]);
            tx_one(lc[k], dv[k], 16 * (k + 1));
        end
        $display("test tx done");
    endtask
    task automatic t_rx();
        logic [11:0] f;
        int n;
        set_fmt(8'h01, 8'h1B);
        wr(3'h4, 8'h08);
        wr(3'h1, 8'h02);
        wait_irq(1'b1);
        rdchk(3'h2, 8'h02, "isr tx");
        wr(3'h1, 8'h01);
        wait_irq(1'b0);
        i_far.send(12'hFFE, 1, 4);
        repeat (40) @(negedge i_clk);
        rdchk(3'h5, 8'h60, "false start");
        f = frame(8'h1B, 8'hC3, n);
        for (int k = 0; k < 3; k++) begin
            // k=1 spoils parity, k=2 restores it for a framing-only case
            f[9] = (k != 0) ? ~f[9] : f[9];
            f[10] = (k != 2);
            i_far.send(f, n, 16);
            wait_irq(1'b1);
            rdchk(3'h5, (k == 0) ? 8'h61 : 8'h65 + 8'(k - 1) * 8'h04,
                  "rx tags");
            rdchk(3'h0, 8'hC3, "rx data");
            rdchk(3'h5, 8'h60, "tags refreshed");
            wait_irq(1'b0);
        end
        $display("test rx done");
    endtask
    task automatic t_loop();
        logic [7:0] s;
        int k;
        wr(3'h4, 8'h13);
        chk({o_txd, o_rts_n, o_dtr_n}, 3'h7, "loop pins");
        cd_n = 1'b0;
        rdchk(3'h6, 8'h33, "loop modem");
        cd_n = 1'b1;
        wr(3'h0, 8'h5C);
        s = 8'h00;
        k = 0;
        while (s[0] !== 1'b1 && k < 40) begin
            rd(3'h5, s);
            k++;
        end
        chk(s[0], 1'b1, "loop rx ready");
        if (k >= 40)
            print_verdict();
        rdchk(3'h0, 8'h5C, "loop data");
        wr(3'h4, 8'h03);
        chk({o_rts_n, o_dtr_n}, 2'h0, "pins back");
        $display("test loop done");
    endtask
    task automatic t_enh();
        wr(3'h4, 8'h04);
        chk(o_rst_out, 1'b0, "soft gated");
        wr(3'h1, 8'h20);
        chk(o_rst_out, 1'b1, "soft reset");
        rdchk(3'h7, 8'hA5, "soft keeps");
        wr(3'h4, 8'h80);
        rdchk(3'h3, 8'h1B, "pdown keeps");
        wr(3'h4, 8'h00);
        tx_one(8'h1B, 8'h3C, 16);
        wr(3'h1, 8'h00);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        rdchk(3'h3, 8'h00, "lcr reset");
        $display("test enhanced done");
    endtask
    initial begin
        repeat (12) @(negedge i_clk);
        chk(o_rst_out, 1'b1, "rst out");
        i_rst = 1'b0;
        t_regs();
        t_tx();
        t_rx();
        t_loop();
        t_enh();
        print_verdict();
    end
endmodule
`default_nettype wire
